// ---- core/tdrc_pkg.sv ----
// Package with constants for the tamper detect and RAM clear block.
package tdrc_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 125000000;
	localparam int SAMPLE_PERIOD_S = 1;
	localparam int SAMPLE_WINDOW_US = 1000;
	localparam int WIPE_DELAY_TYP_US = 1500;
	localparam int RECOVERY_TIME_US = 200000;
	localparam int SECOND_CYCLES = CLK_HZ * SAMPLE_PERIOD_S;
	localparam int WINDOW_CYCLES = (CLK_HZ / 1000000) * SAMPLE_WINDOW_US;
	localparam int WIPE_DELAY_CYCLES = (CLK_HZ / 1000000) * WIPE_DELAY_TYP_US;
	localparam int RECOVERY_CYCLES = (CLK_HZ / 1000000) * RECOVERY_TIME_US;
	// ****************************************
	// Wipe pulse widths in seconds, selected by the two-bit width field
	// ****************************************
	localparam logic [4:0] WIPE_SECS_00 = 5'h01;
	localparam logic [4:0] WIPE_SECS_01 = 5'h04;
	localparam logic [4:0] WIPE_SECS_10 = 5'h08;
	localparam logic [4:0] WIPE_SECS_11 = 5'h10;
	// ****************************************
	// Internal user RAM
	// ****************************************
	localparam int RAM_BYTES = 128;
	localparam int RAM_AW = 7;
	// ****************************************
	// Wipe sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		TDRC_IDLE = 4'h1,
		TDRC_DELAY = 4'h2,
		TDRC_PULSE = 4'h4,
		TDRC_DONE = 4'h8
	} tdrc_wipe_e;
endpackage

// ---- core/tdrc_ram.sv ----
// Internal 128-byte user RAM with a registered read port and a sweeping clear.
`timescale 1ns/1ns
module tdrc_ram
	import tdrc_pkg::*;
#(
	parameter int AW = RAM_AW,
	parameter int DEPTH = RAM_BYTES
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Access port
	input wire logic [AW-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic we_in,
	input wire logic re_in,
	output logic [7:0] rdata_out,
	// Clear control
	input wire logic clear_in,
	output logic clearing_out
);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] clr_ptr_q;
	logic clearing_q;

	assign clearing_out = clearing_q;

	// A clear walks through every byte, one per cycle, writing zero.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			clearing_q <= 1'b0;
			clr_ptr_q <= '0;
		end
		else if (clear_in && !clearing_q)
		begin
			clearing_q <= 1'b1;
			clr_ptr_q <= '0;
		end
		else if (clearing_q)
		begin
			clr_ptr_q <= clr_ptr_q + 1'b1;
			if (clr_ptr_q == AW'(DEPTH - 1))
				clearing_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (clearing_q)
			mem[clr_ptr_q] <= 8'h00;
		else if (we_in)
			mem[addr_in] <= wdata_in;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_out <= 8'h00;
		else if (re_in)
			rdata_out <= mem[addr_in];
	end
endmodule // tdrc_ram

// ---- core/tdrc_chan.sv ----
// One tamper channel: input synchroniser, trigger evaluation and flag.
`timescale 1ns/1ns
module tdrc_chan
	import tdrc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Pin and configuration
	input wire logic pin_in,
	input wire logic enable_in,
	input wire logic switch_mode_in,
	input wire logic polarity_in,
	input wire logic sample_select_in,
	input wire logic pull_strength_in,
	input wire logic osc_running_in,
	input wire logic window_in,
	input wire logic block_in,
	// Results
	output logic pull_enable_out,
	output logic pull_strong_out,
	output logic pull_up_out,
	output logic flag_out,
	output logic event_out
);
	logic sync1_q;
	logic sync2_q;
	logic flag_q;
	logic sampling;
	logic armed;
	logic hit;

	// Two-stage synchroniser; only the second stage is evaluated.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// Sampling only in normally closed mode with a running oscillator.
	assign sampling = !switch_mode_in && sample_select_in && osc_running_in;
	assign armed = enable_in && (!sampling || window_in);
	assign hit = armed && !block_in && (sync2_q == polarity_in) && !flag_q;

	// Pull is driven only in normally closed mode while armed; it pulls toward the trigger level.
	// A closed switch overrides it, so only an opened switch lets the pin reach the trigger level.
	assign pull_enable_out = armed && !switch_mode_in && !flag_q;
	assign pull_strong_out = pull_strength_in && !switch_mode_in;
	assign pull_up_out = polarity_in;
	assign flag_out = flag_q;
	assign event_out = hit;

	// The flag is held until the enable bit is written to zero.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			flag_q <= 1'b0;
		else if (!enable_in)
			flag_q <= 1'b0;
		else if (hit)
			flag_q <= 1'b1;
	end
endmodule // tdrc_chan

// ---- core/tdrc_top.sv ----
// Tamper detect and RAM clear control for two channels.
`timescale 1ns/1ns
module tdrc_top
	import tdrc_pkg::*;
#(
	parameter int SECOND_COUNT = SECOND_CYCLES,
	parameter int WINDOW_COUNT = WINDOW_CYCLES,
	parameter int WIPE_DELAY_COUNT = WIPE_DELAY_CYCLES,
	parameter int RECOVERY_COUNT = RECOVERY_CYCLES
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Tamper pins
	input wire logic tamper_input_ch1_in,
	input wire logic tamper_input_ch2_in,
	// Channel configuration
	input wire logic tamper_enable_ch1_in,
	input wire logic tamper_enable_ch2_in,
	input wire logic tamper_irq_enable_ch1_in,
	input wire logic tamper_irq_enable_ch2_in,
	input wire logic switch_mode_ch1_in,
	input wire logic switch_mode_ch2_in,
	input wire logic trigger_polarity_ch1_in,
	input wire logic trigger_polarity_ch2_in,
	input wire logic sample_select_ch1_in,
	input wire logic sample_select_ch2_in,
	input wire logic pull_strength_ch1_in,
	input wire logic pull_strength_ch2_in,
	input wire logic internal_ram_wipe_ch1_in,
	input wire logic internal_ram_wipe_ch2_in,
	input wire logic external_ram_wipe_ch1_in,
	input wire logic external_ram_wipe_ch2_in,
	input wire logic wipe_width_bit0_in,
	input wire logic wipe_width_bit1_in,
	input wire logic alarm_in_backup_enable_in,
	// System status
	input wire logic battery_mode_in,
	input wire logic oscillator_fail_flag_in,
	input wire logic flags_read_in,
	input wire logic other_reset_req_in,
	// Tamper status
	output logic tamper_flag_ch1_out,
	output logic tamper_flag_ch2_out,
	output logic irq_n_out,
	output logic clock_freeze_out,
	// Pull control per channel
	output logic [1:0] pull_enable_out,
	output logic [1:0] pull_strong_out,
	output logic [1:0] pull_up_out,
	// External wipe and reset
	output logic ext_wipe_strobe_out,
	output logic reset_n_out,
	output logic switched_supply_off_out,
	// User RAM port
	input wire logic [RAM_AW-1:0] ram_addr_in,
	input wire logic [7:0] ram_wdata_in,
	input wire logic ram_we_in,
	input wire logic ram_re_in,
	output logic [7:0] ram_rdata_out,
	output logic ram_deselect_out
);
	// ****************************************
	// Per-channel gathering
	// ****************************************
	logic [1:0] pin;
	logic [1:0] en;
	logic [1:0] irq_en;
	logic [1:0] mode;
	logic [1:0] pol;
	logic [1:0] samp;
	logic [1:0] pstr;
	logic [1:0] iwipe;
	logic [1:0] xwipe;
	logic [1:0] flag;
	logic [1:0] evt;
	logic [1:0] block;
	logic window_q;
	logic tick;
	logic [31:0] sec_cnt_q;
	logic [31:0] win_cnt_q;
	logic [1:0] deselect_q;
	logic freeze_q;
	logic irq_q;
	logic [31:0] dly_cnt_q;
	logic [31:0] rec_cnt_q;
	logic [4:0] sec_left_q;
	logic supply_off_q;
	logic ram_clearing;
	logic tamper_reset;
	logic reset_active;
	logic [4:0] width_secs;
	tdrc_wipe_e wstate_q;

	assign pin = {tamper_input_ch2_in, tamper_input_ch1_in};
	assign en = {tamper_enable_ch2_in, tamper_enable_ch1_in};
	assign irq_en = {tamper_irq_enable_ch2_in, tamper_irq_enable_ch1_in};
	assign mode = {switch_mode_ch2_in, switch_mode_ch1_in};
	assign pol = {trigger_polarity_ch2_in, trigger_polarity_ch1_in};
	assign samp = {sample_select_ch2_in, sample_select_ch1_in};
	assign pstr = {pull_strength_ch2_in, pull_strength_ch1_in};
	assign iwipe = {internal_ram_wipe_ch2_in, internal_ram_wipe_ch1_in};
	assign xwipe = {external_ram_wipe_ch2_in, external_ram_wipe_ch1_in};

	// ****************************************
	// Channels
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_chan
			// High-polarity tampers are masked while the strobe is high.
			assign block[g] = pol[g] && (wstate_q == TDRC_PULSE);
			tdrc_chan u_chan (
				.clk_in(mclk_in),
				.rst_in(sys_rst_in),
				.pin_in(pin[g]),
				.enable_in(en[g]),
				.switch_mode_in(mode[g]),
				.polarity_in(pol[g]),
				.sample_select_in(samp[g]),
				.pull_strength_in(pstr[g]),
				.osc_running_in(!oscillator_fail_flag_in),
				.window_in(window_q),
				.block_in(block[g]),
				.pull_enable_out(pull_enable_out[g]),
				.pull_strong_out(pull_strong_out[g]),
				.pull_up_out(pull_up_out[g]),
				.flag_out(flag[g]),
				.event_out(evt[g])
			);
		end
	endgenerate

	assign tamper_flag_ch1_out = flag[0];
	assign tamper_flag_ch2_out = flag[1];

	// ****************************************
	// Once-per-second sample window
	// ****************************************
	assign tick = (sec_cnt_q == 32'(SECOND_COUNT - 1));

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			sec_cnt_q <= 32'h00000000;
		else if (tick)
			sec_cnt_q <= 32'h00000000;
		else
			sec_cnt_q <= sec_cnt_q + 32'h00000001;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			window_q <= 1'b0;
			win_cnt_q <= 32'h00000000;
		end
		else if (tick)
		begin
			window_q <= 1'b1;
			win_cnt_q <= 32'h00000000;
		end
		else if (window_q)
		begin
			win_cnt_q <= win_cnt_q + 32'h00000001;
			if (win_cnt_q == 32'(WINDOW_COUNT - 1))
				window_q <= 1'b0;
		end
	end

	// ****************************************
	// Interrupt
	// ****************************************
	assign reset_active = (rec_cnt_q != 32'h00000000);

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			irq_q <= 1'b0;
		else if (|(evt & irq_en) && (!battery_mode_in || alarm_in_backup_enable_in))
			irq_q <= 1'b1;
		else if (flags_read_in || !(|irq_en) || reset_active)
			irq_q <= 1'b0;
	end

	assign irq_n_out = !irq_q;

	// ****************************************
	// Clock freeze and internal RAM deselect
	// ****************************************
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			freeze_q <= 1'b0;
		else if (|evt)
			freeze_q <= 1'b1;
		else if (!(|en))
			freeze_q <= 1'b0;
	end

	assign clock_freeze_out = freeze_q;

	generate
		for (g = 0; g < 2; g++)
		begin : g_desel
			always_ff @(posedge mclk_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
					deselect_q[g] <= 1'b0;
				else if (evt[g] && iwipe[g])
					deselect_q[g] <= 1'b1;
				else if (!en[g])
					deselect_q[g] <= 1'b0;
			end
		end
	endgenerate

	assign ram_deselect_out = (|deselect_q) || ram_clearing;

	tdrc_ram u_ram (
		.clk_in(mclk_in),
		.rst_in(sys_rst_in),
		.addr_in(ram_addr_in),
		.wdata_in(ram_wdata_in),
		.we_in(ram_we_in && !ram_deselect_out),
		.re_in(ram_re_in),
		.rdata_out(ram_rdata_out),
		.clear_in(|(evt & iwipe)),
		.clearing_out(ram_clearing)
	);

	// ****************************************
	// External wipe sequencer
	// ****************************************
	always_comb
	begin
		case ({wipe_width_bit1_in, wipe_width_bit0_in})
			2'b00: width_secs = WIPE_SECS_00;
			2'b01: width_secs = WIPE_SECS_01;
			2'b10: width_secs = WIPE_SECS_10;
			default: width_secs = WIPE_SECS_11;
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			wstate_q <= TDRC_IDLE;
			dly_cnt_q <= 32'h00000000;
			sec_left_q <= 5'h00;
		end
		else
		begin
			case (wstate_q)
				TDRC_IDLE:
					if (|(evt & xwipe))
					begin
						wstate_q <= TDRC_DELAY;
						dly_cnt_q <= 32'h00000000;
					end
				TDRC_DELAY:
				begin
					dly_cnt_q <= dly_cnt_q + 32'h00000001;
					if (dly_cnt_q == 32'(WIPE_DELAY_COUNT - 1))
					begin
						wstate_q <= TDRC_PULSE;
						dly_cnt_q <= 32'h00000000;
						sec_left_q <= width_secs;
					end
				end
				TDRC_PULSE:
				begin
					dly_cnt_q <= dly_cnt_q + 32'h00000001;
					if (dly_cnt_q == 32'(SECOND_COUNT - 1))
					begin
						dly_cnt_q <= 32'h00000000;
						sec_left_q <= sec_left_q - 5'h01;
						if (sec_left_q == 5'h01)
							wstate_q <= TDRC_DONE;
					end
				end
				TDRC_DONE:
					if (!(|(en & xwipe)))
						wstate_q <= TDRC_IDLE;
				default:
					wstate_q <= TDRC_IDLE;
			endcase
		end
	end

	assign ext_wipe_strobe_out = (wstate_q == TDRC_PULSE);

	// ****************************************
	// Reset output and supply disconnect
	// ****************************************
	assign tamper_reset = |(evt & xwipe);

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			rec_cnt_q <= 32'h00000000;
		else if (tamper_reset || other_reset_req_in)
			rec_cnt_q <= 32'(RECOVERY_COUNT);
		else if (reset_active)
			rec_cnt_q <= rec_cnt_q - 32'h00000001;
	end

	assign reset_n_out = !reset_active;

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			supply_off_q <= 1'b0;
		else if (tamper_reset && battery_mode_in)
			supply_off_q <= 1'b1;
		else if (!battery_mode_in && wstate_q == TDRC_IDLE)
			supply_off_q <= 1'b0;
	end

	assign switched_supply_off_out = supply_off_q;
endmodule // tdrc_top

// ---- verif/tdrc_top_sva.sv ----
// Concurrent checks on the ports of the tamper detect and RAM clear block.
`timescale 1ns/1ns
module tdrc_chk
#(
	parameter int SECOND_COUNT = 100,
	parameter int WIPE_DELAY_COUNT = 20,
	parameter int RECOVERY_COUNT = 50
)
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Configuration and status
	input wire logic tamper_enable_ch1_in,
	input wire logic tamper_enable_ch2_in,
	input wire logic tamper_irq_enable_ch1_in,
	input wire logic tamper_irq_enable_ch2_in,
	input wire logic external_ram_wipe_ch1_in,
	input wire logic external_ram_wipe_ch2_in,
	input wire logic internal_ram_wipe_ch1_in,
	input wire logic internal_ram_wipe_ch2_in,
	input wire logic wipe_width_bit0_in,
	input wire logic wipe_width_bit1_in,
	input wire logic alarm_in_backup_enable_in,
	input wire logic battery_mode_in,
	input wire logic flags_read_in,
	// Watched outputs
	input wire logic tamper_flag_ch1_out,
	input wire logic tamper_flag_ch2_out,
	input wire logic irq_n_out,
	input wire logic clock_freeze_out,
	input wire logic ext_wipe_strobe_out,
	input wire logic reset_n_out,
	input wire logic ram_deselect_out
);
	localparam int DLO = WIPE_DELAY_COUNT;
	localparam int DHI = WIPE_DELAY_COUNT + 2;
	int hi_q;
	int lo_q;
	int secs;
	assign secs = {wipe_width_bit1_in, wipe_width_bit0_in} == 2'h0 ? 1 :
		2 << {wipe_width_bit1_in, wipe_width_bit0_in};
	// Count the cycles the wipe strobe stays high and the reset output stays low.
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			hi_q <= 0;
			lo_q <= 0;
		end
		else
		begin
			hi_q <= ext_wipe_strobe_out ? hi_q + 1 : 0;
			lo_q <= reset_n_out ? 0 : lo_q + 1;
		end
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	AST_FLAG_CAUSE: assert property ($rose(tamper_flag_ch1_out) |-> $past(tamper_enable_ch1_in))
		else $error("flag 1 rose while disabled");
	AST_FLAG_HOLD: assert property (tamper_flag_ch1_out && tamper_enable_ch1_in |=> tamper_flag_ch1_out)
		else $error("flag 1 dropped while enabled");
	AST_FLAG_CLEAR: assert property (!tamper_enable_ch2_in [*2] |-> !tamper_flag_ch2_out)
		else $error("flag 2 set while disabled");
	AST_IRQ_CAUSE: assert property ($fell(irq_n_out) |-> ($rose(tamper_flag_ch1_out) ||
		$rose(tamper_flag_ch2_out)) && $past(tamper_irq_enable_ch1_in || tamper_irq_enable_ch2_in))
		else $error("interrupt without enabled tamper");
	AST_IRQ_BACKUP: assert property ($fell(irq_n_out) && $past(battery_mode_in) |->
		$past(alarm_in_backup_enable_in))
		else $error("interrupt on battery without alarm enable");
	AST_IRQ_READ: assert property (flags_read_in ##1 !$rose(tamper_flag_ch1_out) &&
		!$rose(tamper_flag_ch2_out) |-> irq_n_out)
		else $error("interrupt not released by flags read");
	AST_IRQ_RST: assert property (!reset_n_out [*2] |-> irq_n_out)
		else $error("interrupt not released by reset");
	AST_WIPE_DELAY: assert property ($rose(tamper_flag_ch1_out) && !$past(clock_freeze_out) &&
		external_ram_wipe_ch1_in && tamper_enable_ch1_in |-> ##[DLO:DHI] $rose(ext_wipe_strobe_out))
		else $error("wipe strobe delay wrong");
	AST_WIPE_WIDTH: assert property ($fell(ext_wipe_strobe_out) |-> hi_q == secs * SECOND_COUNT)
		else $error("wipe strobe width wrong");
	AST_WIPE_CAUSE: assert property ($rose(ext_wipe_strobe_out) |-> !reset_n_out &&
		(external_ram_wipe_ch1_in || external_ram_wipe_ch2_in))
		else $error("wipe strobe without external wipe");
	AST_RESET_LEN: assert property ($rose(reset_n_out) |-> lo_q == RECOVERY_COUNT)
		else $error("reset output length wrong");
	AST_DESEL_HOLD: assert property (ram_deselect_out && tamper_enable_ch1_in &&
		tamper_enable_ch2_in |=> ram_deselect_out)
		else $error("RAM reselected while enabled");
	AST_DESEL_CAUSE: assert property ($rose(ram_deselect_out) |->
		internal_ram_wipe_ch1_in || internal_ram_wipe_ch2_in)
		else $error("RAM deselected without internal wipe");
	AST_FREEZE: assert property ($rose(tamper_flag_ch1_out) || $rose(tamper_flag_ch2_out) |->
		clock_freeze_out)
		else $error("clock not frozen on tamper");
endmodule // tdrc_chk

// ---- verif/tdrc_switch_model.sv ----
// Model of the two external tamper switches and their pin wiring.
`timescale 1ns/1ns
module tdrc_switch_model
(
	// Clock
	input wire logic clk_in,
	// Switch state and wiring
	input wire logic [1:0] closed_in,
	input wire logic [1:0] open_type_in,
	input wire logic [1:0] to_high_in,
	// Internal pull from the device
	input wire logic [1:0] pull_enable_in,
	input wire logic [1:0] pull_up_in,
	// Tamper pins
	output logic [1:0] pin_out
);
	logic float_q = 1'b0;
	always_ff @(posedge clk_in)
		float_q <= ~float_q;
	// An open normally closed switch leaves the pin to the pull, or floating when it is off.
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (open_type_in[i])
				pin_out[i] = closed_in[i] ? to_high_in[i] : ~to_high_in[i];
			else if (closed_in[i])
				pin_out[i] = ~to_high_in[i];
			else
				pin_out[i] = pull_enable_in[i] ? pull_up_in[i] : float_q;
		end
	end
endmodule // tdrc_switch_model

// ---- verif/test_tdrc_top.sv ----
// Self-checking testbench for the tamper detect and RAM clear block.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_tdrc_top;
	localparam int SEC = 100;
	logic mclk_in = 1'b0, sys_rst_in = 1'b1, tamper_input_ch1_in, tamper_input_ch2_in;
	logic tamper_enable_ch1_in = 1'b0, tamper_enable_ch2_in = 1'b0;
	logic tamper_irq_enable_ch1_in = 1'b0, tamper_irq_enable_ch2_in = 1'b0;
	logic switch_mode_ch1_in = 1'b0, switch_mode_ch2_in = 1'b0;
	logic trigger_polarity_ch1_in = 1'b0, trigger_polarity_ch2_in = 1'b0;
	logic sample_select_ch1_in = 1'b0, sample_select_ch2_in = 1'b0;
	logic pull_strength_ch1_in = 1'b0, pull_strength_ch2_in = 1'b0;
	logic internal_ram_wipe_ch1_in = 1'b0, internal_ram_wipe_ch2_in = 1'b0;
	logic external_ram_wipe_ch1_in = 1'b0, external_ram_wipe_ch2_in = 1'b0;
	logic wipe_width_bit0_in = 1'b0, wipe_width_bit1_in = 1'b0, alarm_in_backup_enable_in = 1'b0;
	logic battery_mode_in = 1'b0, oscillator_fail_flag_in = 1'b0, flags_read_in = 1'b0;
	logic other_reset_req_in = 1'b0, ram_we_in = 1'b0, ram_re_in = 1'b0;
	logic [6:0] ram_addr_in = 7'h00;
	logic [7:0] ram_wdata_in = 8'h00;
	logic [7:0] ram_rdata_out;
	logic tamper_flag_ch1_out, tamper_flag_ch2_out, irq_n_out, clock_freeze_out;
	logic ext_wipe_strobe_out, reset_n_out, switched_supply_off_out, ram_deselect_out;
	logic [1:0] pull_enable_out, pull_strong_out, pull_up_out, pins;
	logic [1:0] sw = 2'b11;
	int fail_count = 0, n_tests = 0, cyc = 0, k, w;
	int secs[4] = '{1, 4, 8, 16};
	assign tamper_input_ch1_in = pins[0];
	assign tamper_input_ch2_in = pins[1];
	tdrc_top #(.SECOND_COUNT(SEC), .WINDOW_COUNT(10), .WIPE_DELAY_COUNT(20),
		.RECOVERY_COUNT(50)) tdrc_top_inst (.*);
	tdrc_switch_model tdrc_switch_model_inst (.clk_in(mclk_in), .closed_in(sw),
		.open_type_in({switch_mode_ch2_in, switch_mode_ch1_in}),
		.to_high_in({trigger_polarity_ch2_in, trigger_polarity_ch1_in}),
		.pull_enable_in(pull_enable_out), .pull_up_in(pull_up_out), .pin_out(pins));
	initial
	begin
		forever #4 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in)
		cyc <= sys_rst_in ? 0 : cyc + 1;
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic ram_wr(input logic [6:0] a, input logic [7:0] d);
		ram_addr_in <= a;
		ram_wdata_in <= d;
		ram_we_in <= 1'b1;
		wt(1);
		ram_we_in <= 1'b0;
	endtask
	task automatic ram_rd(input logic [6:0] a, input logic [7:0] e);
		ram_addr_in <= a;
		ram_re_in <= 1'b1;
		wt(1);
		ram_re_in <= 1'b0;
		wt(1);
		`CHK("ram", e, ram_rdata_out)
	endtask
	initial
	begin
		wt(20000);
		fail_count++;
		give_verdict;
	end
	initial
	begin
		wt(2);
		sys_rst_in <= 1'b0;
		wt(1);
		`CHK("flag1", 1'b0, tamper_flag_ch1_out)
		`CHK("strobe", 1'b0, ext_wipe_strobe_out)
		tamper_irq_enable_ch1_in <= 1'b1;
		for (k = 0; k < 4; k++)
		begin
			switch_mode_ch1_in <= k[1];
			trigger_polarity_ch1_in <= k[0];
			pull_strength_ch1_in <= k[0];
			sample_select_ch1_in <= k[1];
			battery_mode_in <= k[1];
			alarm_in_backup_enable_in <= k[0];
			sw[0] <= k[1];
			wt(5);
			`CHK("flag1 off", 1'b0, tamper_flag_ch1_out)
			sw[0] <= ~k[1];
			wt(3);
			tamper_enable_ch1_in <= 1'b1;
			wt(5);
			`CHK("flag1 idle", 1'b0, tamper_flag_ch1_out)
			if (!k[1])
				`CHK("pull", {1'b1, k[0], k[0]}, {pull_enable_out[0], pull_strong_out[0], pull_up_out[0]})
			sw[0] <= k[1];
			wt(4);
			`CHK("flag1 set", 1'b1, tamper_flag_ch1_out)
			`CHK("irq_n", k == 2, irq_n_out)
			`CHK("freeze", 1'b1, clock_freeze_out)
			sw[0] <= ~k[1];
			flags_read_in <= 1'b1;
			wt(1);
			flags_read_in <= 1'b0;
			wt(1);
			`CHK("irq_n read", 1'b1, irq_n_out)
			`CHK("flag1 held", 1'b1, tamper_flag_ch1_out)
			tamper_enable_ch1_in <= 1'b0;
			wt(2);
			`CHK("flag1 clr", 1'b0, tamper_flag_ch1_out)
		end
		battery_mode_in <= 1'b0;
		tamper_enable_ch2_in <= 1'b1;
		sample_select_ch2_in <= 1'b1;
		pull_strength_ch2_in <= 1'b1;
		while (cyc % SEC != 50)
			wt(1);
		sw[1] <= 1'b0;
		wt(30);
		`CHK("flag2 early", 1'b0, tamper_flag_ch2_out)
		wt(40);
		`CHK("flag2 sampled", 1'b1, tamper_flag_ch2_out)
		tamper_enable_ch2_in <= 1'b0;
		sw[1] <= 1'b1;
		oscillator_fail_flag_in <= 1'b1;
		wt(2);
		while (cyc % SEC != 50)
			wt(1);
		tamper_enable_ch2_in <= 1'b1;
		wt(3);
		sw[1] <= 1'b0;
		wt(5);
		`CHK("flag2 osc", 1'b1, tamper_flag_ch2_out)
		tamper_enable_ch2_in <= 1'b0;
		sample_select_ch2_in <= 1'b0;
		sw <= 2'b00;
		switch_mode_ch1_in <= 1'b1;
		trigger_polarity_ch1_in <= 1'b1;
		sample_select_ch1_in <= 1'b0;
		switch_mode_ch2_in <= 1'b1;
		trigger_polarity_ch2_in <= 1'b1;
		internal_ram_wipe_ch1_in <= 1'b1;
		external_ram_wipe_ch1_in <= 1'b1;
		for (w = 0; w < 4; w++)
		begin
			{wipe_width_bit1_in, wipe_width_bit0_in} <= w[1:0];
			battery_mode_in <= w[0];
			wt(2);
			ram_wr(7'h05, 8'hA5);
			ram_rd(7'h05, 8'hA5);
			tamper_enable_ch1_in <= 1'b1;
			tamper_enable_ch2_in <= 1'b1;
			wt(3);
			sw <= 2'b01;
			wt(30);
			`CHK("strobe up", 1'b1, ext_wipe_strobe_out)
			`CHK("reset_n", 1'b0, reset_n_out)
			`CHK("irq_n rst", 1'b1, irq_n_out)
			`CHK("deselect", 1'b1, ram_deselect_out)
			`CHK("supply off", w[0], switched_supply_off_out)
			sw <= 2'b11;
			wt(5);
			`CHK("flag2 blocked", 1'b0, tamper_flag_ch2_out)
			wt(secs[w] * SEC - 25);
			`CHK("strobe held", 1'b1, ext_wipe_strobe_out)
			wt(30);
			`CHK("strobe down", 1'b0, ext_wipe_strobe_out)
			`CHK("deselect held", 1'b1, ram_deselect_out)
			sw <= 2'b00;
			tamper_enable_ch1_in <= 1'b0;
			tamper_enable_ch2_in <= 1'b0;
			wt(3);
			`CHK("deselect off", 1'b0, ram_deselect_out)
			ram_rd(7'h05, 8'h00);
		end
		other_reset_req_in <= 1'b1;
		wt(1);
		other_reset_req_in <= 1'b0;
		wt(3);
		`CHK("reset_n req", 1'b0, reset_n_out)
		wt(60);
		`CHK("reset_n end", 1'b1, reset_n_out)
		give_verdict;
	end
endmodule // test_tdrc_top
bind tdrc_top tdrc_chk #(.SECOND_COUNT(SECOND_COUNT), .WIPE_DELAY_COUNT(WIPE_DELAY_COUNT),
	.RECOVERY_COUNT(RECOVERY_COUNT)) tdrc_chk_inst (.*);
